// >>> inc/ict_cfg.svh
// Purpose: timing constants for the instruction cycle timer
// Assumes: 40 MHz core clock, one count per processor cycle
// Notes: counts are processor cycles, not ns
`ifndef ICT_CFG_SVH
`define ICT_CFG_SVH
`define ICT_FRAME_SETUP_BASE 8'h0F
`define ICT_FRAME_SETUP_PER 8'h04
`define ICT_FRAME_DROP_BASE 8'h0A
`define ICT_FRAME_DROP_PER 8'h01
`define ICT_PIN_BW_INDIR 8'h02
`define ICT_PIN_BW_DIR 8'h01
`define ICT_PIN_L_INDIR 8'h03
`define ICT_PIN_L_DIR 8'h02
`define ICT_BUMP_CYC 8'h04
`define ICT_STEP_BW 8'h0B
`define ICT_STEP_L 8'h0C
`define ICT_REP_BW_BASE 8'h03
`define ICT_REP_L_BASE 8'h04
`define ICT_REP_PER 8'h08
`define ICT_BOUND_W 8'h13
`define ICT_BOUND_L 8'h1B
`endif

// >>> inc/ict_pkg.sv
// Purpose: types for the instruction cycle timer
// Assumes: nothing
// Notes: opcode codes are local to this block
package ict_pkg;
    typedef enum logic [2:0] {
        ICT_OP_FRAME_SETUP = 3'h0,
        ICT_OP_FRAME_DROP = 3'h1,
        ICT_OP_PORT_READ = 3'h2,
        ICT_OP_ATOMIC_BUMP = 3'h3,
        ICT_OP_PORT_READ_DOWN = 3'h4,
        ICT_OP_PORT_READ_UP = 3'h5,
        ICT_OP_PORT_READ_REPEAT = 3'h6,
        ICT_OP_ARRAY_BOUND = 3'h7
    } ict_op_type;
    typedef enum logic [2:0] {
        ICT_ST_IDLE = 3'b001,
        ICT_ST_COUNT = 3'b010,
        ICT_ST_DONE = 3'b100
    } ict_state_type;
    typedef struct packed {
        ict_state_type st;
        logic [11:0] cnt;
        logic [7:0] iter;
        logic [7:0] per;
        logic busy;
        logic done;
        logic miss;
        logic [11:0] total;
    } ict_regs_type;
endpackage : ict_pkg

// >>> rtl/ict_timer.sv
// Purpose: counts out the execution cycles of frame, port-read, bump and bound ops
// Assumes: start_i is a one-cycle pulse taken only while busy_o is low
// Notes: the repeat form adds its per-iteration cost plus waits on every iteration
//
// How it works
// - frame setup 15 plus 4 per register
// - frame teardown 10 plus 1 per register
// - port read 2/1 or 3/2 plus access
// - atomic bump 4 cycles plus mode cycles, counted as miss
// - down step read 11/12 plus waits
// - up step read 11/12 plus waits
// - repeat read 3/4 plus 8 and waits per iteration
// - array bound 19 word, 27 longword, plus mode cycles
`timescale 1ns/100ps
`include "ict_cfg.svh"
module ict_timer
    import ict_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic start_i,
    input wire ict_op_type op_i,
    input wire logic long_i,
    input wire logic indirect_i,
    input wire logic [7:0] count_i,
    input wire logic [3:0] wait_i,
    input wire logic [3:0] mode_cyc_i,
    output logic busy_o,
    output logic done_o,
    output logic miss_o,
    output logic [11:0] total_o
);
    ict_regs_type r;
    ict_regs_type r_nxt;
    logic [11:0] base;
    logic [7:0] per;

    // base part and per-iteration part of the count
    always_comb begin
        base = 12'h000;
        per = 8'h00;
        case (op_i)
            ICT_OP_FRAME_SETUP: begin
                base = {4'h0, `ICT_FRAME_SETUP_BASE} + {2'h0, count_i, 2'h0};
            end
            ICT_OP_FRAME_DROP: begin
                base = {4'h0, `ICT_FRAME_DROP_BASE} + {4'h0, count_i};
            end
            ICT_OP_PORT_READ: begin
                if (long_i) begin
                    base = {4'h0, indirect_i ? `ICT_PIN_L_INDIR : `ICT_PIN_L_DIR};
                end else begin
                    base = {4'h0, indirect_i ? `ICT_PIN_BW_INDIR : `ICT_PIN_BW_DIR};
                end
                base = base + {8'h00, wait_i};
            end
            ICT_OP_ATOMIC_BUMP: begin
                base = {4'h0, `ICT_BUMP_CYC} + {8'h00, mode_cyc_i};
            end
            ICT_OP_PORT_READ_DOWN, ICT_OP_PORT_READ_UP: begin
                base = {4'h0, long_i ? `ICT_STEP_L : `ICT_STEP_BW} + {8'h00, wait_i};
            end
            ICT_OP_PORT_READ_REPEAT: begin
                base = {4'h0, long_i ? `ICT_REP_L_BASE : `ICT_REP_BW_BASE};
                per = `ICT_REP_PER + {4'h0, wait_i};
            end
            ICT_OP_ARRAY_BOUND: begin
                base = {4'h0, long_i ? `ICT_BOUND_L : `ICT_BOUND_W} + {8'h00, mode_cyc_i};
            end
            default: begin
                base = 12'h000;
            end
        endcase
    end

    always_comb begin
        r_nxt = r;
        r_nxt.done = 1'b0;
        case (r.st)
            ICT_ST_IDLE: begin
                if (start_i) begin
                    r_nxt.st = ICT_ST_COUNT;
                    r_nxt.busy = 1'b1;
                    r_nxt.miss = (op_i == ICT_OP_ATOMIC_BUMP);
                    r_nxt.per = per;
                    // repeat form with zero iterations still runs its base cycles
                    r_nxt.iter = (op_i == ICT_OP_PORT_READ_REPEAT) ? count_i : 8'h00;
                    r_nxt.cnt = (base == 12'h000) ? 12'h001 : base;
                    r_nxt.total = 12'h000;
                end
            end
            ICT_ST_COUNT: begin
                r_nxt.total = r.total + 12'h001;
                if (r.cnt > 12'h001) begin
                    r_nxt.cnt = r.cnt - 12'h001;
                // the last base cycle reloads the per-iteration count, so no cycle is lost between iterations
                end else if (r.iter != 8'h00) begin
                    r_nxt.iter = r.iter - 8'h01;
                    r_nxt.cnt = {4'h0, r.per};
                end else begin
                    r_nxt.st = ICT_ST_DONE;
                end
            end
            ICT_ST_DONE: begin
                r_nxt.st = ICT_ST_IDLE;
                r_nxt.busy = 1'b0;
                r_nxt.done = 1'b1;
            end
            default: begin
                r_nxt.st = ICT_ST_IDLE;
                r_nxt.busy = 1'b0;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            r <= '{st: ICT_ST_IDLE, cnt: 12'h000, iter: 8'h00, per: 8'h00,
                   busy: 1'b0, done: 1'b0, miss: 1'b0, total: 12'h000};
        end else begin
            r <= r_nxt;
        end
    end

    assign busy_o = r.busy;
    assign done_o = r.done;
    assign miss_o = r.miss;
    assign total_o = r.total;

    // helper: latched request for checks
    // taken on the same edge as the start, so it holds the count of the op in flight
    logic [11:0] exp_r;
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            exp_r <= 12'h000;
        end else if (start_i && !r.busy) begin
            exp_r <= (op_i == ICT_OP_PORT_READ_REPEAT) ? base + 12'(count_i) * 12'(per) : base;
        end
    end

    // done state seen at one edge, done pulse at the next
    sequence s_finish;
        r.st == ICT_ST_DONE ##1 done_o;
    endsequence

    // the repeat product wraps like the 12-bit total, so long repeats still compare
    a_total_exact: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        done_o |-> (total_o == exp_r))
        else $error("cycle total differs from expected count");
    a_bump_miss: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (start_i && !busy_o && op_i == ICT_OP_ATOMIC_BUMP) |=> miss_o)
        else $error("atomic bump not marked as miss");
    a_miss_clear: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (start_i && !busy_o && op_i != ICT_OP_ATOMIC_BUMP) |=> !miss_o)
        else $error("miss flag left set by a cached op");
    a_start_clear: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (start_i && !busy_o) |=> (busy_o && total_o == 12'h000))
        else $error("start did not raise busy and clear the total");
    a_count_step: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (r.st == ICT_ST_COUNT) |=> (total_o == $past(total_o) + 12'h001))
        else $error("total did not advance during counting");

    // fixed-length checks: start edge, n counting cycles, then the done state
    a_bound_word: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (start_i && !busy_o && op_i == ICT_OP_ARRAY_BOUND && !long_i && mode_cyc_i == 4'h0)
        |=> busy_o [*8] ##12 s_finish)
        else $error("word bound calc not 19 cycles");
    a_bound_long: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (start_i && !busy_o && op_i == ICT_OP_ARRAY_BOUND && long_i && mode_cyc_i == 4'h0)
        |=> ##27 s_finish)
        else $error("longword bound calc not 27 cycles");
    a_step_read: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (start_i && !busy_o && op_i == ICT_OP_PORT_READ_UP && !long_i && wait_i == 4'h0)
        |=> ##11 s_finish)
        else $error("up step read not 11 cycles");
    a_up_long: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (start_i && !busy_o && op_i == ICT_OP_PORT_READ_UP && long_i && wait_i == 4'h0)
        |=> ##12 s_finish)
        else $error("up step long read not 12 cycles");
    a_down_read: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (start_i && !busy_o && op_i == ICT_OP_PORT_READ_DOWN && long_i && wait_i == 4'h0)
        |=> ##12 s_finish)
        else $error("down step long read not 12 cycles");
    a_down_byte: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (start_i && !busy_o && op_i == ICT_OP_PORT_READ_DOWN && !long_i && wait_i == 4'h0)
        |=> ##11 s_finish)
        else $error("down step read not 11 cycles");
    a_port_direct: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (start_i && !busy_o && op_i == ICT_OP_PORT_READ && !long_i && !indirect_i && wait_i == 4'h0)
        |=> ##1 s_finish)
        else $error("direct port read not 1 cycle");
    a_port_indirect: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (start_i && !busy_o && op_i == ICT_OP_PORT_READ && !long_i && indirect_i && wait_i == 4'h0)
        |=> ##2 s_finish)
        else $error("indirect port read not 2 cycles");
    a_drop_frame: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (start_i && !busy_o && op_i == ICT_OP_FRAME_DROP && count_i == 8'h02)
        |=> ##12 s_finish)
        else $error("frame teardown count wrong");
    a_setup_empty: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (start_i && !busy_o && op_i == ICT_OP_FRAME_SETUP && count_i == 8'h00)
        |=> ##15 s_finish)
        else $error("empty frame setup not 15 cycles");
    a_setup_three: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (start_i && !busy_o && op_i == ICT_OP_FRAME_SETUP && count_i == 8'h03)
        |=> ##27 s_finish)
        else $error("three register frame setup not 27 cycles");
    a_repeat_once: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (start_i && !busy_o && op_i == ICT_OP_PORT_READ_REPEAT && long_i && count_i == 8'h01 && wait_i == 4'h0)
        |=> ##12 s_finish)
        else $error("repeat read one iteration not 12 cycles");
    a_repeat_none: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (start_i && !busy_o && op_i == ICT_OP_PORT_READ_REPEAT && !long_i && count_i == 8'h00 && wait_i == 4'h0)
        |=> ##3 s_finish)
        else $error("repeat read without iterations not 3 cycles");
    a_mode_add: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (start_i && !busy_o && op_i == ICT_OP_ATOMIC_BUMP && mode_cyc_i == 4'h2)
        |=> ##6 s_finish)
        else $error("addressing overhead not added");
    a_bump_plain: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (start_i && !busy_o && op_i == ICT_OP_ATOMIC_BUMP && mode_cyc_i == 4'h0)
        |=> ##4 s_finish)
        else $error("atomic bump not 4 cycles");
endmodule : ict_timer

// >>> sim/ict_port_model.sv
// Purpose: input port device that sets the access time and wait states
// Assumes: the bench picks the access time one cycle before a start
// Notes: registered, so a new setting reaches the timer one edge late
`timescale 1ns/100ps
module ict_port_model (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic [3:0] access_i,
    output logic [3:0] wait_o
);
    // a port at rest inserts no waits
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            wait_o <= 4'h0;
        end else begin
            wait_o <= access_i;
        end
    end
endmodule : ict_port_model

// >>> sim/tb_top.sv
// Purpose: self-checking bench for the instruction cycle timer
// Assumes: inputs move 1 ns after the rising edge
// Notes: waits come from the port model; a second start in flight must be ignored
`timescale 1ns/100ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin miscompares++; \
    $display("MISMATCH %0t got %0h exp %0h", $time, a, b); end end
module tb_top
    import ict_pkg::*;
();
    logic ref_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic start_i = 1'b0;
    logic long_i = 1'b0;
    logic indirect_i = 1'b0;
    ict_op_type op_i = ICT_OP_FRAME_SETUP;
    logic [7:0] count_i = 8'h00;
    logic [3:0] acc = 4'h0;
    logic [3:0] wait_w;
    logic [3:0] mode_cyc_i = 4'h0;
    logic busy_o, done_o, miss_o;
    logic [11:0] total_o;
    int miscompares = 0;
    int checked = 0;
    int cycles = 0;
    ict_port_model i_port (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .access_i(acc), .wait_o(wait_w));
    ict_timer i_dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .start_i(start_i), .op_i(op_i),
        .long_i(long_i), .indirect_i(indirect_i), .count_i(count_i), .wait_i(wait_w),
        .mode_cyc_i(mode_cyc_i), .busy_o(busy_o), .done_o(done_o), .miss_o(miss_o), .total_o(total_o));
    initial begin
        forever #12.5 ref_clk_i = ~ref_clk_i;
    end
    task give_verdict;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : give_verdict
    // poke raises start again mid-count; it must change nothing
    task run(input ict_op_type op, input logic lg, input logic indir, input logic [7:0] n,
        input logic [3:0] w, input logic [3:0] m, input logic [11:0] exp_n, input logic exp_miss,
        input bit poke);
        int k;
        acc = w;
        @(posedge ref_clk_i) #1;
        op_i = op; long_i = lg; indirect_i = indir; count_i = n; mode_cyc_i = m; start_i = 1'b1;
        @(posedge ref_clk_i) #1;
        start_i = 1'b0;
        `CHK(busy_o, 1'b1)
        k = 0;
        while (done_o !== 1'b1 && k < 4000) begin
            @(posedge ref_clk_i) #1;
            k++;
            start_i = poke && k == 2;
        end
        // done shows n+1 edges after the start edge
        `CHK(k, exp_n + 1)
        `CHK(total_o, exp_n)
        `CHK(busy_o, 1'b0)
        `CHK(miss_o, exp_miss)
        @(posedge ref_clk_i) #1;
        `CHK(done_o, 1'b0)
        `CHK(total_o, exp_n)
    endtask : run
    // reset in mid-count must drop every output back to rest
    task t_reset_mid;
        op_i = ICT_OP_ATOMIC_BUMP;
        mode_cyc_i = 4'h3;
        start_i = 1'b1;
        @(posedge ref_clk_i) #1;
        start_i = 1'b0;
        @(posedge ref_clk_i) #1;
        `CHK(busy_o, 1'b1)
        `CHK(miss_o, 1'b1)
        rst_n_i = 1'b0;
        repeat (2) @(posedge ref_clk_i);
        #1 rst_n_i = 1'b1;
        `CHK(busy_o, 1'b0)
        `CHK(miss_o, 1'b0)
        `CHK(total_o, 12'h000)
        `CHK(done_o, 1'b0)
        @(posedge ref_clk_i) #1;
        `CHK(busy_o, 1'b0)
        `CHK(done_o, 1'b0)
    endtask : t_reset_mid
    task t_frame;
        run(ICT_OP_FRAME_SETUP, 0, 0, 8'h00, 4'h0, 4'h0, 12'h00F, 0, 0);
        run(ICT_OP_FRAME_SETUP, 0, 0, 8'h03, 4'h0, 4'h0, 12'h01B, 0, 0);
        run(ICT_OP_FRAME_DROP, 0, 0, 8'hFF, 4'h0, 4'h0, 12'h109, 0, 0);
        run(ICT_OP_FRAME_DROP, 0, 0, 8'h05, 4'h0, 4'h0, 12'h00F, 0, 0);
        run(ICT_OP_FRAME_DROP, 0, 0, 8'h02, 4'h0, 4'h0, 12'h00C, 0, 0);
    endtask : t_frame
    task t_port;
        run(ICT_OP_PORT_READ, 0, 1, 8'h00, 4'h0, 4'h0, 12'h002, 0, 0);
        run(ICT_OP_PORT_READ, 0, 0, 8'h00, 4'h3, 4'h0, 12'h004, 0, 0);
        run(ICT_OP_PORT_READ, 1, 1, 8'h00, 4'h1, 4'h0, 12'h004, 0, 0);
        run(ICT_OP_PORT_READ, 1, 0, 8'h00, 4'h0, 4'h5, 12'h002, 0, 0);
        run(ICT_OP_PORT_READ, 0, 0, 8'h00, 4'h0, 4'h0, 12'h001, 0, 0);
    endtask : t_port
    task t_bump_bound;
        run(ICT_OP_ATOMIC_BUMP, 0, 0, 8'h00, 4'h0, 4'h0, 12'h004, 1, 0);
        run(ICT_OP_ATOMIC_BUMP, 0, 0, 8'h00, 4'h0, 4'hF, 12'h013, 1, 0);
        run(ICT_OP_ARRAY_BOUND, 0, 0, 8'h00, 4'h0, 4'h0, 12'h013, 0, 0);
        run(ICT_OP_ARRAY_BOUND, 1, 0, 8'h00, 4'h0, 4'h2, 12'h01D, 0, 1);
        run(ICT_OP_ATOMIC_BUMP, 0, 0, 8'h00, 4'h0, 4'h2, 12'h006, 1, 0);
        run(ICT_OP_ARRAY_BOUND, 1, 0, 8'h00, 4'h0, 4'h0, 12'h01B, 0, 0);
    endtask : t_bump_bound
    task t_step_repeat;
        run(ICT_OP_PORT_READ_DOWN, 0, 1, 8'h00, 4'h0, 4'h0, 12'h00B, 0, 0);
        run(ICT_OP_PORT_READ_DOWN, 1, 1, 8'h00, 4'h2, 4'h0, 12'h00E, 0, 0);
        run(ICT_OP_PORT_READ_UP, 0, 1, 8'h00, 4'h5, 4'h0, 12'h010, 0, 0);
        run(ICT_OP_PORT_READ_UP, 1, 1, 8'h00, 4'h0, 4'h0, 12'h00C, 0, 0);
        run(ICT_OP_PORT_READ_REPEAT, 0, 1, 8'h00, 4'h0, 4'h0, 12'h003, 0, 0);
        run(ICT_OP_PORT_READ_REPEAT, 0, 1, 8'h02, 4'h1, 4'h0, 12'h015, 0, 0);
        run(ICT_OP_PORT_READ_REPEAT, 1, 1, 8'h03, 4'h0, 4'h0, 12'h01C, 0, 0);
        run(ICT_OP_PORT_READ_REPEAT, 1, 1, 8'h01, 4'h0, 4'h0, 12'h00C, 0, 0);
        run(ICT_OP_PORT_READ_UP, 0, 1, 8'h00, 4'h0, 4'h0, 12'h00B, 0, 0);
        run(ICT_OP_PORT_READ_DOWN, 1, 1, 8'h00, 4'h0, 4'h0, 12'h00C, 0, 0);
    endtask : t_step_repeat
    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            give_verdict;
        end
    end
    initial begin
        repeat (16) @(posedge ref_clk_i);
        #1 rst_n_i = 1'b1;
        `CHK(busy_o, 1'b0)
        `CHK(total_o, 12'h000)
        t_frame;
        t_port;
        t_bump_bound;
        t_step_repeat;
        t_reset_mid;
        give_verdict;
    end
endmodule : tb_top
